// file: hw/uef_char_match.sv
// Compares received characters with the flow-control characters.
// Assumes rx_valid is a one-cycle strobe on clk with rx_char stable.
`timescale 1ns/100ps
module uef_char_match
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration
  input wire uef_pkg::uef_chars_t chars,
  input wire logic [1:0] rx_cmp,
  input wire logic rx_both,
  input wire logic spec_en,
  // Received character
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  // Results, one-cycle pulses with rx_valid
  output logic resume_hit,
  output logic pause_hit,
  output logic spec_hit,
  output logic drop_char
);
  import uef_pkg::*;
  logic prev_resume1;
  logic prev_pause1;
  logic r1, r2, p1, p2;

  assign r1 = rx_char == chars.resume_first;
  assign r2 = rx_char == chars.resume_second;
  assign p1 = rx_char == chars.pause_first;
  assign p2 = rx_char == chars.pause_second;

  // Sequence memory for dual-character comparison
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      prev_resume1 <= 1'b0;
      prev_pause1 <= 1'b0;
    end
    else if (rx_valid)
    begin
      prev_resume1 <= r1;
      prev_pause1 <= p1;
    end
  end

  always_comb
  begin
    resume_hit = 1'b0;
    pause_hit = 1'b0;
    if (rx_valid)
    begin
      case (rx_cmp)
        2'b10:
        begin
          resume_hit = r1;
          pause_hit = p1;
        end
        2'b01:
        begin
          resume_hit = r2;
          pause_hit = p2;
        end
        2'b11:
        begin
          if (rx_both)
          begin
            resume_hit = prev_resume1 && r2;
            pause_hit = prev_pause1 && p2;
          end
          else
          begin
            resume_hit = r1 || r2;
            pause_hit = p1 || p2;
          end
        end
        default:
        begin
          resume_hit = 1'b0;
          pause_hit = 1'b0;
        end
      endcase
    end
  end

  assign spec_hit = rx_valid && spec_en && p2;
  assign drop_char = spec_hit && rx_cmp == 2'b01;
endmodule

// file: hw/uef_ctrl.sv
// Enhanced feature and flow control registers of one UART channel.
// Assumes the channel core supplies FIFO counts, transmitter state and
// a one-cycle strobe per received character, all on clk.
`timescale 1ns/100ps
module uef_ctrl
#(
  parameter int BIT_CYCLES = 16,
  parameter logic [7:0] REVISION = uef_pkg::UEF_REV_DEFAULT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Channel core status
  input wire logic [7:0] rx_count,
  input wire logic [7:0] tx_count,
  input wire logic thr_empty,
  input wire logic tsr_empty,
  input wire logic tx_char_busy,
  input wire logic tx_push,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic [7:0] rx_upper,
  input wire logic [7:0] rx_lower,
  // Serial pins
  input wire logic rx_pin,
  input wire logic cts_n_pin,
  output logic rts_n,
  output logic rx_data,
  // Results to the channel core
  output uef_pkg::uef_cfg_t cfg,
  output uef_pkg::uef_ext_t ext,
  output logic tx_halt,
  output logic tx_irq,
  output logic rx_trig_irq,
  output logic rx_store,
  output logic pause_irq,
  output logic spec_irq,
  output logic remote_paused
);
  import uef_pkg::*;

  // Bit timer is 16 bits wide and must count at least one cycle
  if (BIT_CYCLES < 1 || BIT_CYCLES > 65535)
  begin : g_bit_cycles_bad
    $error("BIT_CYCLES out of range");
  end

  logic [7:0] line_control;
  logic [7:0] feature_control;
  logic [7:0] enhanced_feature_control;
  logic [7:0] modem_control;
  logic [7:0] scratch;
  logic [7:0] enhanced_mode_select;
  logic [15:0] divisor;
  uef_chars_t chars;
  uef_ext_t ext_q;
  logic [7:0] rx_trig;
  logic [7:0] tx_trig;
  logic spec_seen;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic wr_enh;
  logic rd_enh;
  logic [7:0] rd_addr;
  logic [7:0] wdat;
  logic [31:0] next_rdata;
  logic rx_s1, rx_s2, cts_s1, cts_s2;

  ////////////////////////////////////////////////////////////////////////////
  // Bus: zero-wait slave, writes land at the data phase
  wire access = hsel && hready && htrans[1];

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      wr_enh <= 1'b0;
    end
    else
    begin
      wr_pend <= access && hwrite;
      wr_addr <= haddr[7:0];
      wr_enh <= line_control == UEF_ENH_LCR;
    end
  end

  assign wdat = hwdata[7:0];
  assign rd_addr = haddr[7:0];
  assign rd_enh = line_control == UEF_ENH_LCR;
  wire do_wr = wr_pend;
  wire ext_open = enhanced_feature_control[UEF_EF_ENH];

  ////////////////////////////////////////////////////////////////////////////
  // Plain control registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      line_control <= UEF_RST_ZERO;
      divisor <= 16'h0001;
      chars <= '0;
    end
    else if (do_wr)
    begin
      if (wr_addr == UEF_A_LINE)
        line_control <= wdat;
      if (wr_addr == UEF_A_DIV)
        divisor <= hwdata[15:0];
      if (wr_addr == UEF_A_CHR)
        chars <= hwdata;
    end
  end

  // Enhanced-only registers reachable while line_control is 0xbf
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      feature_control <= UEF_RST_ZERO;
      enhanced_feature_control <= UEF_RST_ZERO;
    end
    else if (do_wr && wr_enh)
    begin
      if (wr_addr == UEF_A_FEAT)
        feature_control <= wdat;
      if (wr_addr == UEF_A_EFC)
        enhanced_feature_control <= wdat;
    end
  end

  // Trigger levels; only used with table D
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rx_trig <= UEF_RST_ZERO;
      tx_trig <= UEF_RST_ZERO;
    end
    else if (do_wr && wr_enh && wr_addr == UEF_A_TRIG)
    begin
      if (feature_control[UEF_FC_TSEL])
        tx_trig <= wdat;
      else
        rx_trig <= wdat;
    end
  end

  // Scratchpad and its swapped write target
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      scratch <= UEF_RST_SCR;
      enhanced_mode_select <= UEF_RST_EMS;
    end
    else if (do_wr && wr_addr == UEF_A_SCR)
    begin
      if (feature_control[UEF_FC_SWAP])
        enhanced_mode_select <= wdat;
      else
        scratch <= wdat;
    end
  end

  // Extended bits: writable only while enhanced enable is set
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ext_q <= '0;
      modem_control <= UEF_RST_ZERO;
    end
    else if (do_wr)
    begin
      if (wr_addr == UEF_A_EXT && ext_open)
        ext_q <= {hwdata[3:0], hwdata[5:4], hwdata[7:6], hwdata[10:8],
                  hwdata[23:16]};
      if (wr_addr == UEF_A_STAT)
        modem_control[4:0] <= wdat[4:0];
      if (wr_addr == UEF_A_STAT && ext_open)
        modem_control[7:5] <= wdat[7:5];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (rd_addr)
      UEF_A_LINE: next_rdata = {24'h0, line_control};
      UEF_A_FEAT: next_rdata = rd_enh ? {24'h0, feature_control} : 32'h0;
      UEF_A_EFC:
        next_rdata = rd_enh ? {24'h0, enhanced_feature_control} : 32'h0;
      UEF_A_FILL:
        if (rd_enh)
          next_rdata = {24'h0,
                        feature_control[UEF_FC_TSEL] ? tx_count : rx_count};
      UEF_A_REV: next_rdata = {24'h0, REVISION};
      UEF_A_SCR:
        next_rdata = {24'h0, feature_control[UEF_FC_SWAP] ?
                      (enhanced_mode_select[0] ? tx_count : rx_count) :
                      scratch};
      UEF_A_EXT:
        next_rdata = {8'h0, ext_q.fraction, 5'h0, ext_q.mcr_hi,
                      ext_q.fcr_hi, ext_q.isr_hi, ext_q.ier_hi};
      UEF_A_DIV: next_rdata = {16'h0, divisor};
      UEF_A_CHR: next_rdata = chars;
      UEF_A_STAT:
        next_rdata = {22'h0, spec_seen, remote_paused, modem_control};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      hrdata <= 32'h0000_0000;
    else if (access && !hwrite)
      hrdata <= next_rdata;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and ir receive polarity
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rx_s1 <= 1'b0;
      rx_s2 <= 1'b0;
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
    end
    else
    begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
      cts_s1 <= cts_n_pin;
      cts_s2 <= cts_s1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      rx_data <= 1'b0;
    else
      rx_data <= rx_s2 ^ feature_control[UEF_FC_IRINV];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration to the core
  always_ff @(posedge clk)
  begin
    if (!resetn)
      cfg <= '0;
    else
    begin
      cfg.rx_trig <= rx_trig;
      cfg.tx_trig <= tx_trig;
      cfg.table_sel <= feature_control[5:4];
      cfg.hyst <= feature_control[1:0];
      cfg.tx_flow <= enhanced_feature_control[3:2];
      cfg.rx_cmp <= enhanced_feature_control[1:0];
      cfg.tx_dual <= &enhanced_feature_control[3:2];
      cfg.rx_either <= &enhanced_feature_control[1:0] &&
                       ^enhanced_feature_control[3:2];
      cfg.rx_both <= &enhanced_feature_control[1:0] &&
                     !(^enhanced_feature_control[3:2]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      ext <= '0;
    else
      ext <= ext_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive character comparison
  logic resume_hit, pause_hit, spec_hit, drop_char;
  wire rx_both_cmp = !(^enhanced_feature_control[3:2]);

  uef_char_match u_match
  (
    .clk(clk),
    .resetn(resetn),
    .chars(chars),
    .rx_cmp(enhanced_feature_control[1:0]),
    .rx_both(rx_both_cmp),
    .spec_en(enhanced_feature_control[UEF_EF_SPEC]),
    .rx_valid(rx_valid),
    .rx_char(rx_char),
    .resume_hit(resume_hit),
    .pause_hit(pause_hit),
    .spec_hit(spec_hit),
    .drop_char(drop_char)
  );

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rx_store <= 1'b0;
      pause_irq <= 1'b0;
      spec_irq <= 1'b0;
      remote_paused <= 1'b0;
    end
    else
    begin
      rx_store <= rx_valid && !drop_char;
      pause_irq <= pause_hit;
      spec_irq <= spec_hit && ext_q.ier_hi[1];
      if (pause_hit)
        remote_paused <= 1'b1;
      else if (resume_hit)
        remote_paused <= 1'b0;
    end
  end

  // Sticky special-character flag; a new hit beats the clear
  always_ff @(posedge clk)
  begin
    if (!resetn)
      spec_seen <= 1'b0;
    else if (spec_hit)
      spec_seen <= 1'b1;
    else if (do_wr && wr_addr == UEF_A_STAT && hwdata[9])
      spec_seen <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit interrupt, direction control and cts halt
  localparam logic [15:0] BIT_CNT = 16'(BIT_CYCLES);
  logic [15:0] bit_timer;
  logic dir_tx;
  wire dir_mode = feature_control[UEF_FC_DIR];

  always_ff @(posedge clk)
  begin
    if (!resetn)
      tx_irq <= 1'b0;
    else if (dir_mode)
      tx_irq <= thr_empty && tsr_empty;
    else
      tx_irq <= thr_empty;
  end

  // Direction stays transmit until one bit time after the shifter empties
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      dir_tx <= 1'b0;
      bit_timer <= 16'h0000;
    end
    else if (tx_push)
    begin
      dir_tx <= 1'b1;
      bit_timer <= BIT_CNT;
    end
    else if (dir_tx && tsr_empty && thr_empty)
    begin
      if (bit_timer == 16'h0001)
        dir_tx <= 1'b0;
      bit_timer <= bit_timer - 16'h0001;
    end
    else
      bit_timer <= BIT_CNT;
  end

  // Auto rts: release at or above the upper level, reassert below the lower one
  logic rts_hold;
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rts_hold <= 1'b0;
      rx_trig_irq <= 1'b0;
    end
    else
    begin
      rx_trig_irq <= enhanced_feature_control[UEF_EF_ARTS] &&
                     rx_count >= rx_upper;
      if (rx_count >= rx_upper)
        rts_hold <= 1'b1;
      else if (rx_count < rx_lower)
        rts_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      rts_n <= 1'b1;
    else if (dir_mode)
      rts_n <= dir_tx ~^ enhanced_mode_select[UEF_EM_INV];
    else if (enhanced_feature_control[UEF_EF_ARTS])
      rts_n <= rts_hold || !modem_control[UEF_MC_RTS];
    else
      rts_n <= !modem_control[UEF_MC_RTS];
  end

  // Halt takes effect only between characters
  always_ff @(posedge clk)
  begin
    if (!resetn)
      tx_halt <= 1'b0;
    else if (!enhanced_feature_control[UEF_EF_ACTS])
      tx_halt <= 1'b0;
    else if (!tx_char_busy)
      tx_halt <= cts_s2;
  end
endmodule

// file: hw/uef_pkg.sv
// Constants, register map and carriers for the enhanced flow/feature block.
// Assumes one AHB-Lite slave port; FIFO counts and character events come
// from the rest of the UART channel on the same clock.
// Function
// - Trigger write goes to rx or tx
// - Fill count only at line_control 0xbf
// - Two-bit hysteresis field, reset zero
// - Ir receive inversion selects idle polarity
// - Plain mode: interrupt when holding empties
// - Direction mode: rts high one bit after
// - Rts low on fifo write; inversion bit
// - Trigger table select A to D
// - Scratchpad swap: level read, mode write
// - Transmit software flow selection
// - Receive comparison selection, either or both
// - Dual modes use two-character sequences
// - Enhanced enable gates extended bit writes
// - Extended bits clear on reset
// - Special character matches pause_char_second
// - Second-pair compare: special match not stored
// - Auto rts follows trigger and hysteresis
// - Auto cts halts and resumes transmit
// - Current character finishes before halt
// - Direction rts low in transmit default
package uef_pkg;
  localparam logic [7:0] UEF_ENH_LCR = 8'hbf;
  // Register byte addresses
  localparam logic [7:0] UEF_A_LINE = 8'h00;
  localparam logic [7:0] UEF_A_FEAT = 8'h04;
  localparam logic [7:0] UEF_A_EFC = 8'h08;
  localparam logic [7:0] UEF_A_TRIG = 8'h0c;
  localparam logic [7:0] UEF_A_FILL = 8'h10;
  localparam logic [7:0] UEF_A_REV = 8'h14;
  localparam logic [7:0] UEF_A_SCR = 8'h18;
  localparam logic [7:0] UEF_A_EXT = 8'h1c;
  localparam logic [7:0] UEF_A_DIV = 8'h20;
  localparam logic [7:0] UEF_A_CHR = 8'h24;
  localparam logic [7:0] UEF_A_STAT = 8'h28;
  // Reset values
  localparam logic [7:0] UEF_RST_ZERO = 8'h00;
  localparam logic [7:0] UEF_RST_SCR = 8'hff;
  localparam logic [7:0] UEF_RST_EMS = 8'h80;
  // Arbitrary revision value
  localparam logic [7:0] UEF_REV_DEFAULT = 8'h5a;
  // Bit positions
  localparam int UEF_FC_IRINV = 2;
  localparam int UEF_FC_DIR = 3;
  localparam int UEF_FC_SWAP = 6;
  localparam int UEF_FC_TSEL = 7;
  localparam int UEF_EF_ENH = 4;
  localparam int UEF_EF_SPEC = 5;
  localparam int UEF_EF_ARTS = 6;
  localparam int UEF_EF_ACTS = 7;
  localparam int UEF_EM_INV = 3;
  localparam int UEF_MC_RTS = 1;
  localparam logic [1:0] UEF_TBL_D = 2'b11;

  typedef struct packed {
    logic [7:0] resume_first;
    logic [7:0] resume_second;
    logic [7:0] pause_first;
    logic [7:0] pause_second;
  } uef_chars_t;

  typedef struct packed {
    logic [3:0] ier_hi;
    logic [1:0] isr_hi;
    logic [1:0] fcr_hi;
    logic [2:0] mcr_hi;
    logic [7:0] fraction;
  } uef_ext_t;

  typedef struct packed {
    logic [7:0] rx_trig;
    logic [7:0] tx_trig;
    logic [1:0] table_sel;
    logic [1:0] hyst;
    logic [1:0] tx_flow;
    logic [1:0] rx_cmp;
    logic tx_dual;
    logic rx_either;
    logic rx_both;
  } uef_cfg_t;
endpackage

// file: tb/testbench.sv
// Bench for the enhanced feature block: bus tasks, one task per scenario.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
module testbench;
  import uef_pkg::*;
  localparam int BITC = 4;
  // Arbitrary revision value
  localparam logic [7:0] REV_CODE = 8'h3c;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, rx_pin, cts_n_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] rx_count, tx_count, rx_char;
  logic thr_empty, tsr_empty, tx_char_busy, tx_push, rx_valid;
  logic pause, line, rts_n, rx_data, tx_halt, tx_irq, rx_trig_irq;
  logic rx_store, pause_irq, spec_irq, remote_paused;
  logic [2:0] seen;
  uef_cfg_t cfg;
  uef_ext_t ext;
  int err_total, checked;
  uef_ctrl #(.BIT_CYCLES(BITC), .REVISION(REV_CODE)) i_uef_ctrl (.clk,
    .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_count, .tx_count,
    .thr_empty, .tsr_empty, .tx_char_busy, .tx_push, .rx_valid, .rx_char,
    .rx_upper(8'h30), .rx_lower(8'h10), .rx_pin, .cts_n_pin, .rts_n,
    .rx_data, .cfg, .ext, .tx_halt, .tx_irq, .rx_trig_irq, .rx_store,
    .pause_irq, .spec_irq, .remote_paused);
  uef_remote_model i_uef_remote_model (.clk, .pause, .line, .cts_n_pin,
    .rx_pin);
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Hold each phase until hready is seen high at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic rxsend(input logic [7:0] c);
    seen = 3'b000;
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      seen |= {rx_store, pause_irq, spec_irq};
    end
  endtask
  task automatic push();
    @(posedge clk);
    tx_push <= 1'b1;
    @(posedge clk);
    tx_push <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    chk(32'(rts_n), 32'h1);
    wr(UEF_A_DIV, 32'h0);
    rdchk(UEF_A_REV, {24'h0, REV_CODE});
    rdchk(UEF_A_SCR, 32'hff);
    wr(UEF_A_SCR, 32'h5c);
    rdchk(UEF_A_SCR, 32'h5c);
    wr(UEF_A_LINE, 32'hbf);
    rdchk(UEF_A_FEAT, 32'h0);
    rdchk(UEF_A_EFC, 32'h0);
    rdchk(UEF_A_EXT, 32'h0);
  endtask
  task automatic t_fill();
    wr(UEF_A_LINE, 32'h03);
    rdchk(UEF_A_FILL, 32'h0);
    wr(UEF_A_LINE, 32'hbf);
    wr(UEF_A_FEAT, 32'h80);
    rdchk(UEF_A_FILL, 32'h07);
    wr(UEF_A_FEAT, 32'h00);
    rdchk(UEF_A_FILL, 32'h21);
  endtask
  task automatic t_trig();
    wr(UEF_A_FEAT, 32'hb0);
    wr(UEF_A_TRIG, 32'h30);
    wr(UEF_A_FEAT, 32'h30);
    wr(UEF_A_TRIG, 32'h18);
    wt(2);
    chk({cfg.tx_trig, cfg.rx_trig}, 32'h3018);
    for (int i = 0; i < 4; i++)
    begin
      wr(UEF_A_FEAT, {26'h0, i[1:0], 2'h0, i[1:0]});
      wt(2);
      chk({cfg.table_sel, cfg.hyst}, {i[1:0], i[1:0]});
    end
  endtask
  task automatic t_efc();
    logic [3:0] e;
    for (int v = 0; v < 16; v++)
    begin
      e = v[3:0];
      wr(UEF_A_EFC, 32'h0);
      wr(UEF_A_EFC, {28'h0, e});
      wt(2);
      chk({cfg.tx_flow, cfg.rx_cmp, cfg.tx_dual, cfg.rx_either, cfg.rx_both},
        {e, e[3:2] == 2'b11, e[1:0] == 2'b11 && ^e[3:2],
        e[1:0] == 2'b11 && !(^e[3:2])});
    end
  endtask
  task automatic t_ext();
    wr(UEF_A_EFC, 32'h0);
    wr(UEF_A_EXT, 32'h00aa073f);
    rdchk(UEF_A_EXT, 32'h0);
    wr(UEF_A_EFC, 32'h10);
    wr(UEF_A_EXT, 32'h00aa073f);
    wr(UEF_A_EFC, 32'h0);
    wr(UEF_A_EXT, 32'h0);
    rdchk(UEF_A_EXT, 32'h00aa073f);
    chk(ext, {4'hf, 2'h3, 2'h0, 3'h7, 8'haa});
  endtask
  task automatic t_cts();
    wr(UEF_A_EFC, 32'h80);
    tx_char_busy <= 1'b1;
    pause <= 1'b1;
    wt(8);
    chk(32'(tx_halt), 32'h0);
    tx_char_busy <= 1'b0;
    wt(3);
    chk(32'(tx_halt), 32'h1);
    pause <= 1'b0;
    wt(8);
    chk(32'(tx_halt), 32'h0);
  endtask
  task automatic t_dir();
    int n;
    tsr_empty <= 1'b0;
    tx_char_busy <= 1'b1;
    wr(UEF_A_FEAT, 32'h00);
    wt(3);
    chk(32'(tx_irq), 32'h1);
    wr(UEF_A_FEAT, 32'h08);
    thr_empty <= 1'b0;
    push();
    wt(3);
    chk({rts_n, tx_irq}, 32'h0);
    thr_empty <= 1'b1;
    wt(3);
    chk({rts_n, tx_irq}, 32'h0);
    tsr_empty <= 1'b1;
    tx_char_busy <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (rts_n !== 1'b1 && n < 20);
    chk(32'(n >= BITC && n <= BITC + 3), 32'h1);
    chk(32'(tx_irq), 32'h1);
    wr(UEF_A_FEAT, 32'h48);
    wr(UEF_A_SCR, 32'h08);
    rdchk(UEF_A_SCR, 32'h21);
    wt(3);
    chk(32'(rts_n), 32'h0);
    push();
    wt(3);
    chk(32'(rts_n), 32'h1);
    wr(UEF_A_FEAT, 32'h00);
  endtask
  task automatic t_ir();
    wr(UEF_A_FEAT, 32'h04);
    line <= 1'b1;
    wt(6);
    chk(32'(rx_data), 32'h0);
    wr(UEF_A_FEAT, 32'h00);
    wt(6);
    chk(32'(rx_data), 32'h1);
    line <= 1'b0;
  endtask
  task automatic t_arts();
    wr(UEF_A_STAT, 32'h02);
    wr(UEF_A_EFC, 32'h40);
    wt(2);
    chk({rts_n, rx_trig_irq}, 32'h0);
    rx_count <= 8'h30;
    wt(3);
    chk({rts_n, rx_trig_irq}, 32'h3);
    rx_count <= 8'h20;
    wt(3);
    chk({rts_n, rx_trig_irq}, 32'h2);
    rx_count <= 8'h0f;
    wt(3);
    chk({rts_n, rx_trig_irq}, 32'h0);
    rx_count <= 8'h21;
    wr(UEF_A_STAT, 32'h00);
  endtask
  task automatic t_spec();
    wr(UEF_A_CHR, 32'h11121314);
    wr(UEF_A_EFC, 32'h20);
    rxsend(8'h14);
    chk(seen, 3'b101);
    rdchk(UEF_A_STAT, 32'h200);
    wr(UEF_A_STAT, 32'h200);
    rdchk(UEF_A_STAT, 32'h0);
    rxsend(8'h55);
    chk(seen, 3'b100);
    wr(UEF_A_EFC, 32'h0);
    wr(UEF_A_EFC, 32'h21);
    rxsend(8'h14);
    chk(seen, 3'b011);
    chk(32'(remote_paused), 32'h1);
    wr(UEF_A_EFC, 32'h0);
    wr(UEF_A_EFC, 32'h0f);
    rxsend(8'h13);
    rxsend(8'h14);
    chk(seen, 3'b110);
    rxsend(8'h11);
    rxsend(8'h12);
    chk(32'(remote_paused), 32'h0);
    rdchk(UEF_A_STAT, 32'h200);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    {resetn, hsel, hwrite, tx_char_busy, tx_push, rx_valid, pause} = 7'h0;
    {thr_empty, tsr_empty} = 2'b11;
    {haddr, hwdata, htrans, rx_char, line} = 75'h0;
    // Counts stay still while the fill count is read
    rx_count = 8'h21;
    tx_count = 8'h07;
    {err_total, checked} = 64'h0;
    wt(5);
    resetn <= 1'b1;
    wt(2);
    t_reset_vals();
    t_fill();
    t_trig();
    t_efc();
    t_ext();
    t_cts();
    t_dir();
    t_ir();
    t_arts();
    t_spec();
    print_verdict();
  end
  // Whole run needs a few hundred cycles
  initial
  begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule

// file: tb/uef_ctrl_sva.sv
// Concurrent checks on the ports of the enhanced feature block.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/100ps
module uef_ctrl_sva
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Core side
  input wire logic thr_empty,
  input wire logic rx_valid,
  input wire logic cts_n_pin,
  // Results
  input wire uef_pkg::uef_cfg_t cfg,
  input wire logic tx_irq,
  input wire logic tx_halt,
  input wire logic rx_store,
  input wire logic pause_irq,
  input wire logic spec_irq,
  input wire logic remote_paused
);
  import uef_pkg::*;
  logic [1:0] rxv_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // Result pulses may lag a received character by one or two cycles
  always_ff @(posedge clk)
    if (!resetn)
      rxv_q <= 2'b00;
    else
      rxv_q <= {rxv_q[0], rx_valid};
  bus_ready_a: assert property ($past(resetn) |-> hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  either_mode_a: assert property (
    cfg.rx_either |-> cfg.rx_cmp == 2'b11 && ^cfg.tx_flow)
    else $error("either-pair compare in wrong mode");
  both_mode_a: assert property (
    cfg.rx_cmp == 2'b11 |-> cfg.rx_both == !(^cfg.tx_flow))
    else $error("both-pair compare mismatch");
  dual_send_a: assert property (
    cfg.tx_dual == (cfg.tx_flow == 2'b11))
    else $error("dual send mismatch");
  irq_holding_a: assert property (
    !thr_empty [*3] |-> !tx_irq)
    else $error("transmit interrupt with holding full");
  store_cause_a: assert property (rx_store |-> |rxv_q)
    else $error("store without received character");
  pause_cause_a: assert property (pause_irq |-> |rxv_q)
    else $error("pause interrupt without character");
  spec_cause_a: assert property (spec_irq |-> |rxv_q)
    else $error("special interrupt without character");
  drop_match_a: assert property (
    spec_irq && cfg.rx_cmp == 2'b01 |-> !rx_store)
    else $error("matched pause character was stored");
  cts_resume_a: assert property (
    (!cts_n_pin && !remote_paused) [*6] |-> !tx_halt)
    else $error("halt held while CTS low");
  cover property (spec_irq);
  cover property (pause_irq && !rx_store);
  cover property (tx_halt);
  cover property (cfg.rx_either);
endmodule
bind uef_ctrl uef_ctrl_sva i_uef_ctrl_sva (.clk, .resetn, .hreadyout,
  .hresp, .thr_empty, .rx_valid, .cts_n_pin, .cfg, .tx_irq, .tx_halt,
  .rx_store, .pause_irq, .spec_irq, .remote_paused);

// file: tb/uef_remote_model.sv
// Far-side serial device: drives the CTS line and the receive pin.
// Assumes the bench steers pause and line level between characters.
`timescale 1ns/100ps
module uef_remote_model
(
  // Clock
  input wire logic clk,
  // Bench control
  input wire logic pause,
  input wire logic line,
  // Pins toward the block
  output logic cts_n_pin,
  output logic rx_pin
);
  ////////////////////////////////////////////////////////////
  // High on CTS asks the block to stop sending
  always_ff @(posedge clk) cts_n_pin <= pause;
  // Idle level follows the chosen infrared polarity
  always_ff @(posedge clk) rx_pin <= line;
endmodule
